//--- shared/itc_cfg.svh
// Purpose: Offsets, reset values and timing figures of the input conditioning block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Values in 10 mV, 0.01 %, 0.1 s, 10 ms and 10 Hz steps as named below.
`ifndef ITC_CFG_SVH
`define ITC_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ITC_OFF_CURVE_SEL   8'h00
`define ITC_OFF_BELOW_SEL   8'h04
`define ITC_OFF_POLARITY    8'h08
`define ITC_OFF_DELAY_BASE  8'h0C
`define ITC_OFF_CAL_BASE    8'h18
`define ITC_OFF_RAW_MON     8'h28
`define ITC_OFF_PULSE_MAX   8'h2C
`define ITC_OFF_PULSE_FILT  8'h30
`define ITC_OFF_RESTORE     8'h34
`define ITC_OFF_PULSE_MON   8'h38
`define ITC_OFF_CURVE_BASE  8'h40
`define ITC_OFF_CURVE_LAST  8'h6C

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define ITC_CURVE_SEL_RST   12'h321
`define ITC_BELOW_SEL_RST   12'h000
`define ITC_POLARITY_RST    5'h00
`define ITC_DELAY_RST       16'h0000
`define ITC_DELAY_MAX       16'h8CA0
`define ITC_CAL_LIMIT       16'h03E8
`define ITC_PULSE_MAX_RST   16'h1388
`define ITC_PULSE_MAX_TOP   16'h2710
`define ITC_PULSE_FILT_RST  16'h000A
`define ITC_PULSE_FILT_MAX  16'h03E8
`define ITC_FULL_SCALE      16'h2710
`define ITC_CURVE_IN_MAX    16'h03E8
`define ITC_DIGIT_ONE       4'h1
`define ITC_DIGIT_THREE     4'h3
`define ITC_DIGIT_FIVE      4'h5
`define ITC_HZ_PER_STEP     16'h000A

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ITC_CLK_HZ          25000000
`define ITC_DELAY_STEP_MS   100
`define ITC_PULSE_GATE_MS   10

`endif

//--- shared/itc_pkg.sv
// Purpose: Types shared by the input conditioning block.
// Assumes: Values are signed 16-bit fixed point.
// Notes:   Constants live in itc_cfg.svh.
package itc_pkg;

  typedef logic signed [15:0] val_t;

  typedef enum logic [1:0] {
    CURVE_TWO_POINT,
    CURVE_FOUR_POINT,
    CURVE_INVALID
  } curve_kind_t;

endpackage

//--- verilog/input_delay_filter.sv
// Purpose: Holds off a level change until it has stood for a programmed number of steps.
// Assumes: tick_i pulses once per delay step.
// Notes:   The first step may be partial, so the delay is short by up to one step.
`timescale 1ns/1ps
`include "itc_cfg.svh"

module input_delay_filter
  import itc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Control
  input  wire logic        tick_i,
  input  wire logic [15:0] delay_i,
  // Level
  input  wire logic        level_i,
  output logic             level_o
);

  logic        level_q;
  logic        level_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  always_comb begin
    level_d = level_q;
    cnt_d   = cnt_q;
    if (level_i == level_q) begin
      cnt_d = `ITC_DELAY_RST;
    end else if (cnt_q >= delay_i) begin
      level_d = level_i;
      cnt_d   = `ITC_DELAY_RST;
    end else if (tick_i) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_q <= 1'b0;
      cnt_q   <= `ITC_DELAY_RST;
    end else begin
      level_q <= level_d;
      cnt_q   <= cnt_d;
    end
  end

  assign level_o = level_q;

endmodule

//--- verilog/input_terminal_conditioning.sv
// Purpose: Conditions five digital inputs, a pulse input and one analog input.
// Assumes: Pins synchronous to REF_CLK_I; DIN_I high means terminal closed to common.
// Notes:   Registers over APB; answer has no wait states, read data is registered.
// Contract
// - Pulse frequency is measured only on the fifth digital input.
// - Curve selector units digit: 1 to 3 two-point, 4 and 5 four-point.
// - Curve selector resets to 321, selecting curve 1; upper digits reserved.
// - Below minimum input: digit 0 gives minimum setting, digit 1 gives zero.
// - Below-minimum selector resets to 000; only units digit acts.
// - Inputs one to three delay state changes, 0 to 3600 s in 0.1 s.
// - Inputs four and five take effect without programmable delay.
// - One polarity digit per input, units digit is input one, default 00000.
// - Polarity 0 active when closed to common, 1 active when open.
// - Two true and shown voltage pairs correct gain and offset, within 10 V.
// - Factory restore reloads calibration pairs with factory-corrected values.
// - Uncorrected sampled analog voltage is readable in a monitor register.
// - Pulse frequency maps linearly, zero to 0 %, maximum to 100 %.
// - Pulse frequency is filtered with a time constant up to 10 s.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "itc_cfg.svh"

module input_terminal_conditioning
  import itc_pkg::*;
#(
  parameter int          DELAY_STEP_CYC = `ITC_CLK_HZ / 1000 * `ITC_DELAY_STEP_MS,
  parameter int          PULSE_GATE_CYC = `ITC_CLK_HZ / 1000 * `ITC_PULSE_GATE_MS,
  parameter logic [15:0] CAL_TRUE_A     = 16'h00C8,  // factory-corrected pairs
  parameter logic [15:0] CAL_SHOWN_A    = 16'h00C8,
  parameter logic [15:0] CAL_TRUE_B     = 16'h0320,
  parameter logic [15:0] CAL_SHOWN_B    = 16'h0320
)(
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        SYS_RST_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Field inputs
  input  wire logic [4:0]  DIN_I,
  input  wire logic [15:0] ANALOG_SAMPLE_I,
  input  wire logic        ANALOG_VALID_I,
  input  wire logic [15:0] ANALOG_EXT_SETTING_I,
  // Conditioned results
  output logic [4:0]       DIN_ACTIVE_O,
  output logic [15:0]      ANALOG_SETTING_O,
  output logic             ANALOG_EXT_SEL_O,
  output logic [15:0]      PULSE_SETTING_O
);

  // ----------------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------------
  function automatic logic signed [31:0] lin(input logic signed [31:0] x,
                                             input logic signed [31:0] x0,
                                             input logic signed [31:0] y0,
                                             input logic signed [31:0] x1,
                                             input logic signed [31:0] y1);
    if (x1 == x0) begin
      lin = y0;
    end else begin
      lin = y0 + ((x - x0) * (y1 - y0)) / (x1 - x0);
    end
  endfunction

  function automatic logic [15:0] sat(input logic signed [31:0] v,
                                      input logic signed [31:0] lo,
                                      input logic signed [31:0] hi);
    if (v < lo) begin
      sat = lo[15:0];
    end else if (v > hi) begin
      sat = hi[15:0];
    end else begin
      sat = v[15:0];
    end
  endfunction

  localparam logic signed [31:0] CAL_LIM = 32'(signed'(`ITC_CAL_LIMIT));
  localparam logic signed [31:0] FS      = 32'(signed'(`ITC_FULL_SCALE));

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [11:0] curve_sel_q,  curve_sel_d;
  logic [11:0] below_sel_q,  below_sel_d;
  logic [4:0]  polarity_q,   polarity_d;
  logic [15:0] delay_q   [3];
  logic [15:0] delay_d   [3];
  logic [15:0] cal_q     [4];
  logic [15:0] cal_d     [4];
  logic [15:0] cpt_q     [12];
  logic [15:0] cpt_d     [12];
  logic [15:0] raw_q,        raw_d;
  logic [15:0] pmax_q,       pmax_d;
  logic [15:0] pfilt_q,      pfilt_d;
  logic [31:0] prdata_q,     prdata_d;
  logic        slverr_q,     slverr_d;

  logic        setup;
  logic        wr_en;
  logic        mapped;
  logic        restore;
  logic [31:0] rd_val;
  logic [31:0] wsx;

  assign setup   = PSEL_I && !PENABLE_I;
  assign wr_en   = PSEL_I && PENABLE_I && PWRITE_I && mapped;
  assign restore = wr_en && (PADDR_I == `ITC_OFF_RESTORE) && PWDATA_I[0];
  assign wsx     = {{16{PWDATA_I[15]}}, PWDATA_I[15:0]};

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h00000000;
    case (PADDR_I)
      `ITC_OFF_CURVE_SEL:               rd_val = {20'h00000, curve_sel_q};
      `ITC_OFF_BELOW_SEL:               rd_val = {20'h00000, below_sel_q};
      `ITC_OFF_POLARITY:                rd_val = {27'h0000000, polarity_q};
      `ITC_OFF_DELAY_BASE + 8'h00:      rd_val = {16'h0000, delay_q[0]};
      `ITC_OFF_DELAY_BASE + 8'h04:      rd_val = {16'h0000, delay_q[1]};
      `ITC_OFF_DELAY_BASE + 8'h08:      rd_val = {16'h0000, delay_q[2]};
      `ITC_OFF_CAL_BASE + 8'h00:        rd_val = {{16{cal_q[0][15]}}, cal_q[0]};
      `ITC_OFF_CAL_BASE + 8'h04:        rd_val = {{16{cal_q[1][15]}}, cal_q[1]};
      `ITC_OFF_CAL_BASE + 8'h08:        rd_val = {{16{cal_q[2][15]}}, cal_q[2]};
      `ITC_OFF_CAL_BASE + 8'h0C:        rd_val = {{16{cal_q[3][15]}}, cal_q[3]};
      `ITC_OFF_RAW_MON:                 rd_val = {{16{raw_q[15]}}, raw_q};
      `ITC_OFF_PULSE_MAX:               rd_val = {16'h0000, pmax_q};
      `ITC_OFF_PULSE_FILT:              rd_val = {16'h0000, pfilt_q};
      `ITC_OFF_RESTORE:                 rd_val = 32'h00000000;
      `ITC_OFF_PULSE_MON:               rd_val = {16'h0000, PULSE_SETTING_O};
      default: begin
        if (PADDR_I >= `ITC_OFF_CURVE_BASE && PADDR_I <= `ITC_OFF_CURVE_LAST
            && PADDR_I[1:0] == 2'b00) begin
          rd_val = {{16{cpt_q[4'(PADDR_I[5:2])][15]}}, cpt_q[4'(PADDR_I[5:2])]};
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  always_comb begin
    curve_sel_d = curve_sel_q;
    below_sel_d = below_sel_q;
    polarity_d  = polarity_q;
    delay_d     = delay_q;
    cal_d       = cal_q;
    cpt_d       = cpt_q;
    raw_d       = ANALOG_VALID_I ? ANALOG_SAMPLE_I : raw_q;
    pmax_d      = pmax_q;
    pfilt_d     = pfilt_q;
    prdata_d    = setup ? rd_val : prdata_q;
    slverr_d    = setup ? !mapped : slverr_q;
    if (restore) begin
      curve_sel_d = `ITC_CURVE_SEL_RST;
      below_sel_d = `ITC_BELOW_SEL_RST;
      polarity_d  = `ITC_POLARITY_RST;
      delay_d     = '{default: `ITC_DELAY_RST};
      cal_d       = '{CAL_TRUE_A, CAL_SHOWN_A, CAL_TRUE_B, CAL_SHOWN_B};
      pmax_d      = `ITC_PULSE_MAX_RST;
      pfilt_d     = `ITC_PULSE_FILT_RST;
    end else if (wr_en) begin
      case (PADDR_I)
        `ITC_OFF_CURVE_SEL:          curve_sel_d = PWDATA_I[11:0];
        `ITC_OFF_BELOW_SEL:          below_sel_d = PWDATA_I[11:0];
        `ITC_OFF_POLARITY:           polarity_d  = PWDATA_I[4:0];
        `ITC_OFF_DELAY_BASE + 8'h00: delay_d[0]  = sat({16'h0000, PWDATA_I[15:0]}, 0,
                                                       `ITC_DELAY_MAX);
        `ITC_OFF_DELAY_BASE + 8'h04: delay_d[1]  = sat({16'h0000, PWDATA_I[15:0]}, 0,
                                                       `ITC_DELAY_MAX);
        `ITC_OFF_DELAY_BASE + 8'h08: delay_d[2]  = sat({16'h0000, PWDATA_I[15:0]}, 0,
                                                       `ITC_DELAY_MAX);
        `ITC_OFF_CAL_BASE + 8'h00:   cal_d[0] = sat(wsx, -CAL_LIM, CAL_LIM);
        `ITC_OFF_CAL_BASE + 8'h04:   cal_d[1] = sat(wsx, -CAL_LIM, CAL_LIM);
        `ITC_OFF_CAL_BASE + 8'h08:   cal_d[2] = sat(wsx, -CAL_LIM, CAL_LIM);
        `ITC_OFF_CAL_BASE + 8'h0C:   cal_d[3] = sat(wsx, -CAL_LIM, CAL_LIM);
        `ITC_OFF_PULSE_MAX:          pmax_d  = sat({16'h0000, PWDATA_I[15:0]}, 1,
                                                   `ITC_PULSE_MAX_TOP);
        `ITC_OFF_PULSE_FILT:         pfilt_d = sat({16'h0000, PWDATA_I[15:0]}, 0,
                                                   `ITC_PULSE_FILT_MAX);
        default: begin
          if (PADDR_I >= `ITC_OFF_CURVE_BASE) begin
            cpt_d[4'(PADDR_I[5:2])] = PWDATA_I[15:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      curve_sel_q <= `ITC_CURVE_SEL_RST;
      below_sel_q <= `ITC_BELOW_SEL_RST;
      polarity_q  <= `ITC_POLARITY_RST;
      delay_q     <= '{default: `ITC_DELAY_RST};
      cal_q       <= '{CAL_TRUE_A, CAL_SHOWN_A, CAL_TRUE_B, CAL_SHOWN_B};
      for (int i = 0; i < 12; i++) begin
        cpt_q[i] <= (i % 4 == 2) ? `ITC_CURVE_IN_MAX :
                    (i % 4 == 3) ? `ITC_FULL_SCALE : 16'h0000;
      end
      raw_q       <= 16'h0000;
      pmax_q      <= `ITC_PULSE_MAX_RST;
      pfilt_q     <= `ITC_PULSE_FILT_RST;
      prdata_q    <= 32'h00000000;
      slverr_q    <= 1'b0;
    end else begin
      curve_sel_q <= curve_sel_d;
      below_sel_q <= below_sel_d;
      polarity_q  <= polarity_d;
      delay_q     <= delay_d;
      cal_q       <= cal_d;
      cpt_q       <= cpt_d;
      raw_q       <= raw_d;
      pmax_q      <= pmax_d;
      pfilt_q     <= pfilt_d;
      prdata_q    <= prdata_d;
      slverr_q    <= slverr_d;
    end
  end

  assign PRDATA_O  = prdata_q;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && slverr_q;

  // ----------------------------------------------------------------------
  // Digital inputs
  // ----------------------------------------------------------------------
  logic [4:0]  level;
  logic [4:0]  din_q;
  logic [4:0]  din_d;
  logic [2:0]  delayed;
  logic [22:0] step_q, step_d;
  logic        step_tick;

  assign level     = DIN_I ^ polarity_q;
  assign step_tick = (step_q == 23'(DELAY_STEP_CYC - 1));

  for (genvar g = 0; g < 3; g++) begin : g_delay
    input_delay_filter u_delay (
      .clk_i   (REF_CLK_I),
      .rst_i   (SYS_RST_I),
      .tick_i  (step_tick),
      .delay_i (delay_q[g]),
      .level_i (level[g]),
      .level_o (delayed[g])
    );
  end

  always_comb begin
    step_d = step_tick ? 23'h000000 : step_q + 23'h000001;
    din_d  = {level[4:3], delayed};
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      step_q <= 23'h000000;
      din_q  <= 5'h00;
    end else begin
      step_q <= step_d;
      din_q  <= din_d;
    end
  end

  assign DIN_ACTIVE_O = din_q;

  // ----------------------------------------------------------------------
  // Pulse input
  // ----------------------------------------------------------------------
  // The gate is short so the reading follows fast; resolution is one edge per gate.
  logic        pin5_q;
  logic [19:0] gate_q, gate_d;
  logic [15:0] edges_q, edges_d;
  logic [31:0] pfreq_q, pfreq_d;
  logic [15:0] pset_q, pset_d;
  logic        gate_end;
  logic [31:0] meas_hz;

  assign gate_end = (gate_q == 20'(PULSE_GATE_CYC - 1));
  assign meas_hz  = 32'(edges_q) * (32'd1000 / 32'(`ITC_PULSE_GATE_MS));

  always_comb begin
    gate_d  = gate_end ? 20'h00000 : gate_q + 20'h00001;
    edges_d = edges_q;
    if (DIN_I[4] && !pin5_q) begin
      edges_d = edges_q + 16'h0001;
    end
    pfreq_d = pfreq_q;
    if (gate_end) begin
      // An edge in the closing cycle opens the next gate, so that none is lost.
      edges_d = {15'h0000, DIN_I[4] && !pin5_q};
      pfreq_d = pfreq_q + 32'(signed'(meas_hz - pfreq_q)
                              / signed'(32'(pfilt_q) + 32'h00000001));
    end
    pset_d = sat(lin(pfreq_q, 0, 0, 32'(pmax_q) * 32'(`ITC_HZ_PER_STEP), FS),
                 0, FS);
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      pin5_q  <= 1'b0;
      gate_q  <= 20'h00000;
      edges_q <= 16'h0000;
      pfreq_q <= 32'h00000000;
      pset_q  <= 16'h0000;
    end else begin
      pin5_q  <= DIN_I[4];
      gate_q  <= gate_d;
      edges_q <= edges_d;
      pfreq_q <= pfreq_d;
      pset_q  <= pset_d;
    end
  end

  assign PULSE_SETTING_O = pset_q;

  // ----------------------------------------------------------------------
  // Analog input
  // ----------------------------------------------------------------------
  curve_kind_t        kind;
  logic [3:0]         unit;
  logic [3:0]         base;
  logic signed [31:0] cal_v;
  logic signed [31:0] pmin_in, pmin_set, pmax_in, pmax_set;
  logic [15:0]        aset_q, aset_d;
  logic               below;

  function automatic logic signed [31:0] sx(input logic [15:0] v);
    sx = 32'(signed'(v));
  endfunction

  assign unit    = curve_sel_q[3:0];
  assign kind    = (unit >= `ITC_DIGIT_ONE && unit <= `ITC_DIGIT_THREE) ? CURVE_TWO_POINT :
                   (unit > `ITC_DIGIT_THREE && unit <= `ITC_DIGIT_FIVE) ? CURVE_FOUR_POINT :
                   CURVE_INVALID;
  assign base    = (kind == CURVE_TWO_POINT) ? 4'((unit - `ITC_DIGIT_ONE) << 2) : 4'h0;
  assign pmin_in  = sx(cpt_q[base]);
  assign pmin_set = sx(cpt_q[base + 4'h1]);
  assign pmax_in  = sx(cpt_q[base + 4'h2]);
  assign pmax_set = sx(cpt_q[base + 4'h3]);
  assign below    = cal_v < pmin_in;

  always_comb begin
    if (cal_q[1] == cal_q[3]) begin
      cal_v = sx(raw_q);
    end else begin
      cal_v = sx(sat(lin(sx(raw_q), sx(cal_q[1]), sx(cal_q[0]), sx(cal_q[3]), sx(cal_q[2])),
                     -CAL_LIM, CAL_LIM));
    end
    aset_d = aset_q;
    case (kind)
      CURVE_TWO_POINT: begin
        if (below) begin
          aset_d = below_sel_q[3:0] == `ITC_DIGIT_ONE ? 16'h0000 : pmin_set[15:0];
        end else if (cal_v >= pmax_in) begin
          aset_d = pmax_set[15:0];
        end else begin
          aset_d = sat(lin(cal_v, pmin_in, pmin_set, pmax_in, pmax_set), -FS, FS);
        end
      end
      CURVE_FOUR_POINT: aset_d = ANALOG_EXT_SETTING_I;
      default:          aset_d = aset_q;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      aset_q <= 16'h0000;
    end else begin
      aset_q <= aset_d;
    end
  end

  assign ANALOG_SETTING_O = aset_q;
  assign ANALOG_EXT_SEL_O = (kind == CURVE_FOUR_POINT);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_restore_write;
    wr_en && PADDR_I == `ITC_OFF_RESTORE && PWDATA_I[0];
  endsequence

  a_curve_default: assert property ($fell(SYS_RST_I) |-> curve_sel_q == `ITC_CURVE_SEL_RST
                                    && below_sel_q == `ITC_BELOW_SEL_RST)
    else $error("Selectors not at default after reset.");
  a_below_zero: assert property (kind == CURVE_TWO_POINT && below && below_sel_q[3:0] == 4'h1
                                 |=> ANALOG_SETTING_O == 16'h0000)
    else $error("Below-minimum result not zero.");
  a_below_hold: assert property (kind == CURVE_TWO_POINT && below && below_sel_q[3:0] == 4'h0
                                 |=> ANALOG_SETTING_O == $past(pmin_set[15:0]))
    else $error("Below-minimum result not the minimum setting.");
  a_fast_inputs: assert property (##1 DIN_ACTIVE_O[4:3] == $past(DIN_I[4:3] ^ polarity_q[4:3]))
    else $error("Inputs four and five delayed.");
  a_delay_zero: assert property (delay_q[0] == 16'h0000 && $stable(level[0]) [*2]
                                 |=> DIN_ACTIVE_O[0] == $past(level[0]))
    else $error("Undelayed input one did not follow.");
  a_cal_range: assert property (sx(cal_q[0]) <= CAL_LIM && sx(cal_q[0]) >= -CAL_LIM
                                && sx(cal_q[3]) <= CAL_LIM && sx(cal_q[3]) >= -CAL_LIM)
    else $error("Calibration value out of range.");
  a_cal_restore: assert property (s_restore_write |=> cal_q[0] == CAL_TRUE_A
                                  && cal_q[3] == CAL_SHOWN_B)
    else $error("Restore did not reload calibration.");
  a_raw_monitor: assert property (ANALOG_VALID_I |=> raw_q == $past(ANALOG_SAMPLE_I))
    else $error("Raw monitor not updated.");
  a_pulse_cap: assert property (PULSE_SETTING_O <= `ITC_FULL_SCALE)
    else $error("Pulse setting above full scale.");

endmodule

//--- verification/field_wiring.sv
// Purpose: Field side of the input block: contacts, pulse sources, analog source.
// Assumes: Bench sets contact states, pulse enables and the applied voltage.
// Notes:   Analog sample strobes every fourth clock.
`timescale 1ns/1ps

module field_wiring (
  // Clock
  input  wire logic        clk_i,
  // Field conditions
  input  wire logic [4:0]  closed_i,
  input  wire logic [4:0]  pulse_en_i,
  input  wire logic [15:0] volts_i,
  // Terminal levels
  output logic [4:0]       din_o,
  output logic [15:0]      sample_o,
  output logic             valid_o
);
  logic [4:0] toggle_q = 5'h00;
  logic [1:0] div_q    = 2'h0;

  always_ff @(posedge clk_i) begin
    toggle_q <= toggle_q ^ pulse_en_i;
    div_q    <= div_q + 2'h1;
    valid_o  <= (div_q == 2'h3);
  end

  // A pulse source rides on the contact level of its terminal.
  assign din_o    = closed_i ^ toggle_q;
  // The sample bus is not held between strobes, so it shows a wrong value.
  assign sample_o = valid_o ? volts_i : ~volts_i;
endmodule

//--- verification/input_terminal_conditioning_bench.sv
// Purpose: Self-checking bench for the input conditioning block.
// Assumes: Short delay step and pulse gate parameters.
// Notes:   Registers are reached over APB.
`timescale 1ns/1ps

module input_terminal_conditioning_bench;
  import itc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_q;
  logic        pready, pslverr, err, valid, ext_sel;
  logic [4:0]  closed = 5'h00, pulse_en = 5'h00, din, active;
  logic [15:0] volts = 16'h0000, ext = 16'h1234, sample, setting, pulse;
  int          n_fail = 0, checked = 0, cyc = 0;

  always #20 clk = ~clk;

  field_wiring wire_model (.clk_i(clk), .closed_i(closed), .pulse_en_i(pulse_en),
    .volts_i(volts), .din_o(din), .sample_o(sample), .valid_o(valid));

  input_terminal_conditioning #(.DELAY_STEP_CYC(8), .PULSE_GATE_CYC(16)) dut (
    .REF_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .DIN_I(din),
    .ANALOG_SAMPLE_I(sample), .ANALOG_VALID_I(valid), .ANALOG_EXT_SETTING_I(ext),
    .DIN_ACTIVE_O(active), .ANALOG_SETTING_O(setting), .ANALOG_EXT_SEL_O(ext_sel),
    .PULSE_SETTING_O(pulse));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask

  task automatic ana(input logic [15:0] v, input logic [15:0] exp);
    volts <= v;
    repeat (12) @(posedge clk);
    chk({16'h0000, setting}, {16'h0000, exp});
  endtask

  task automatic t_reset;
    logic [7:0]  a [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h2C, 8'h30};
    logic [31:0] v [9] = '{32'h321, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hC8, 32'h1388,
                           32'hA};
    for (int i = 0; i < 9; i++) rd(a[i], v[i]);
    rd(8'h70, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_digital;
    chk({27'h0, active}, 32'h00);
    wr(8'h0C, 32'h2);
    closed <= 5'h09;
    repeat (3) @(posedge clk);
    chk({27'h0, active}, 32'h08);
    repeat (25) @(posedge clk);
    chk({27'h0, active}, 32'h09);
    wr(8'h08, 32'h1F);
    repeat (30) @(posedge clk);
    chk({27'h0, active}, 32'h16);
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h0);
    closed <= 5'h00;
    repeat (3) @(posedge clk);
    chk({27'h0, active}, 32'h00);
    $display("test digital done");
  endtask

  task automatic t_analog;
    ana(16'h01F4, 16'h1388);
    ana(16'h05DC, 16'h2710);
    wr(8'h44, 32'h7D0);
    ana(16'hFF9C, 16'h07D0);
    rd(8'h28, 32'hFFFFFF9C);
    wr(8'h04, 32'h1);
    ana(16'hFF9C, 16'h0000);
    wr(8'h04, 32'h110);
    ana(16'hFF9C, 16'h07D0);
    wr(8'h18, 32'hC8);
    wr(8'h1C, 32'hFA);
    wr(8'h20, 32'h320);
    wr(8'h24, 32'h352);
    ana(16'h0352, 16'h20D0);
    wr(8'h1C, 32'h7D0);
    rd(8'h1C, 32'h3E8);
    wr(8'h34, 32'h1);
    rd(8'h1C, 32'hC8);
    $display("test analog done");
  endtask

  task automatic t_curve;
    logic [15:0] e;
    for (int d = 1; d <= 5; d++) begin
      e = (d == 1) ? 16'h1770 : (d <= 3) ? 16'h1388 : 16'h1234;
      wr(8'h00, 32'h320 | d);
      ana(16'h01F4, e);
      chk({31'h0, ext_sel}, (d >= 4) ? 32'h1 : 32'h0);
    end
    wr(8'h00, 32'h321);
    ana(16'h0064, 16'h0AF0);
    // A curve digit of zero is not a curve, so the last result stays.
    wr(8'h00, 32'h320);
    ana(16'h01F4, 16'h0AF0);
    $display("test curve done");
  endtask

  task automatic t_pulse;
    wr(8'h30, 32'h0);
    pulse_en <= 5'h08;
    repeat (80) @(posedge clk);
    chk({16'h0, pulse}, 32'h0);
    pulse_en <= 5'h10;
    repeat (80) @(posedge clk);
    chk({31'h0, pulse != 16'h0000}, 32'h1);
    chk({31'h0, pulse <= 16'h2710}, 32'h1);
    // Eight edges per gate read as 800 Hz, which is 1.60 % of the 50 kHz default.
    chk({16'h0, pulse}, 32'hA0);
    rd(8'h38, 32'hA0);
    wr(8'h30, 32'h1);
    pulse_en <= 5'h00;
    repeat (40) @(posedge clk);
    chk({31'h0, pulse != 16'h0000 && pulse < 16'h00A0}, 32'h1);
    $display("test pulse done");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict;
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_digital;
    t_analog;
    t_curve;
    t_pulse;
    give_verdict;
  end
endmodule
